// [rtl/nvpc_top.sv]
// nvpc_top: eprom/eeprom program and erase control with eeprom array
// assumes one clock MCLK (the e clock), cpu register and memory ports
// synchronous to it, SPECIAL_MODE high in test or bootstrap modes
//
// The implementer's own choices: the register offsets and the plain strobed port.
`include "nvpc_cfg.svh"

module nvpc_top #(
    parameter int EE_LARGE = 0
) (
    input  wire logic              MCLK,
    input  wire logic              RESETN,
    input  wire logic              SPECIAL_MODE,
    input  wire logic              EE_VISIBLE,
    input  wire logic [3:0]        EE_BASE,
    input  wire logic              RC_OSC,
    input  wire logic [1:0]        REG_ADDR,
    input  wire logic [7:0]        REG_WDATA,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    output logic [7:0]             REG_RDATA,
    input  wire logic [15:0]       MEM_ADDR,
    input  wire logic [7:0]        MEM_WDATA,
    input  wire logic              MEM_WR,
    input  wire logic              MEM_RD,
    output logic [7:0]             MEM_RDATA,
    output logic                   EE_VPP,
    output logic                   EE_BUSY,
    output logic                   PUMP_CLK,
    output nvpc_pkg::nvpc_eprom_s  EPROM
);
    import nvpc_pkg::*;

    localparam int EE_AW   = (EE_LARGE != 0) ? 11 : 9;
    localparam int EE_SIZE = 1 << EE_AW;

    nvpc_state_s s_q;
    nvpc_state_s s_d;
    logic [7:0]  arr [EE_SIZE];
    logic        arr_we;
    logic [10:0] arr_wa;
    logic [7:0]  arr_wd;
    logic        ee_hit;
    logic        cfg_hit;
    logic        ep_hit;
    logic [10:0] mem_off;
    logic        op_prot;
    logic [7:0]  op_old;
    logic        win_open;
    logic        both_req;
    logic        eeprom_voltage_enable_ok;

    // protect decode for one eeprom offset
    function automatic logic blk_prot(input logic [10:0] a, input logic [3:0] bprt);
        logic [1:0] blk;
        blk = 2'd3;
        if (EE_LARGE != 0) begin
            blk = a[10:9];
        end else if (a < `NVPC_EE_BLK1) begin
            blk = 2'd0;
        end else if (a < `NVPC_EE_BLK2) begin
            blk = 2'd1;
        end else if (a < `NVPC_EE_BLK3) begin
            blk = 2'd2;
        end
        return bprt[blk];
    endfunction : blk_prot

    always_comb begin
        mem_off = 11'(MEM_ADDR[10:0] & 11'(EE_SIZE - 1));
        if (EE_LARGE != 0) begin
            ee_hit = EE_VISIBLE && MEM_ADDR[15:12] == EE_BASE && MEM_ADDR[11];
        end else begin
            ee_hit = EE_VISIBLE && MEM_ADDR[15:9] == `NVPC_EE_SM_TAG;
        end
        cfg_hit = MEM_ADDR == `NVPC_CFG_ADDR;
        ep_hit  = MEM_ADDR >= `NVPC_EPROM_BASE;
    end

    // the operation runs one address a cycle, so a bulk erase takes
    // the whole array size in cycles, far below the software hold time
    always_comb begin
        op_old = arr[s_q.op_addr[EE_AW-1:0]];
        if (s_q.ee_cfg) begin
            op_prot = s_q.bp[`NVPC_BP_OPTION_WORD_PROTECT];
        end else begin
            op_prot = blk_prot(s_q.op_addr, s_q.bp[3:0]);
        end
        arr_we = s_q.op_busy && s_q.pe_eeprom_voltage_enable && !s_q.ee_cfg && !op_prot;
        arr_wa = s_q.op_addr;
        if (s_q.pe_erase) begin
            arr_wd = 8'hff;
        end else begin
            arr_wd = op_old & s_q.ee_data;
        end
    end

    always_comb begin
        win_open = s_q.win_cnt < `NVPC_PROT_WIN;
        both_req = REG_WDATA[`NVPC_PE_EEPROM_LATCH_ENABLE] && REG_WDATA[`NVPC_PE_EEPROM_VOLTAGE_ENABLE];
        eeprom_voltage_enable_ok  = s_q.pe_eeprom_latch_enable && s_q.seq inside {SEQ_LOADED, SEQ_HV};
    end

    always_comb begin
        s_d = s_q;
        s_d.rdata  = 8'h00;
        s_d.mrdata = 8'h00;
        if (win_open) begin
            s_d.win_cnt = 7'(s_q.win_cnt + 7'h01);
        end

        // register writes
        if (REG_WR) begin
            unique case (REG_ADDR)
                `NVPC_OFS_EPROM_PROGRAM_REGISTER: begin
                    if (SPECIAL_MODE) begin
                        s_d.ep_mbe  = REG_WDATA[`NVPC_EP_MBE];
                        s_d.ep_xcol = REG_WDATA[`NVPC_EP_XCOL];
                        s_d.ep_xrow = REG_WDATA[`NVPC_EP_XROW];
                        s_d.ep_t    = nvpc_stress_e'(
                            REG_WDATA[`NVPC_EP_T_HI:`NVPC_EP_T_LO]);
                    end
                    if (!s_q.ep_pgm) begin
                        s_d.ep_eprom_latch_enable = REG_WDATA[`NVPC_EP_EPROM_LATCH_ENABLE];
                    end
                    if (s_q.ep_eprom_latch_enable) begin
                        s_d.ep_pgm = REG_WDATA[`NVPC_EP_PGM];
                    end
                end
                `NVPC_OFS_EEPROM_BLOCK_PROTECT: begin
                    if (SPECIAL_MODE || win_open) begin
                        s_d.bp = REG_WDATA[4:0];
                    end else begin
                        s_d.bp = s_q.bp | REG_WDATA[4:0];
                    end
                end
                `NVPC_OFS_PECTL: begin
                    s_d.pe_byte  = REG_WDATA[`NVPC_PE_BYTE];
                    s_d.pe_row   = REG_WDATA[`NVPC_PE_ROW];
                    s_d.pe_erase = REG_WDATA[`NVPC_PE_ERASE];
                    if (!s_q.pe_eeprom_latch_enable && both_req) begin
                        s_d.pe_eeprom_latch_enable = 1'b0;
                        s_d.pe_eeprom_voltage_enable  = 1'b0;
                        s_d.seq      = SEQ_IDLE;
                    end else begin
                        s_d.pe_eeprom_latch_enable = REG_WDATA[`NVPC_PE_EEPROM_LATCH_ENABLE];
                        s_d.pe_eeprom_voltage_enable  = both_req && eeprom_voltage_enable_ok;
                        if (!REG_WDATA[`NVPC_PE_EEPROM_LATCH_ENABLE]) begin
                            s_d.seq = SEQ_IDLE;
                        end else if (s_d.pe_eeprom_voltage_enable) begin
                            s_d.seq = SEQ_HV;
                        end else if (!s_q.pe_eeprom_latch_enable) begin
                            s_d.seq = SEQ_ARMED;
                        end else if (s_q.seq == SEQ_HV) begin
                            s_d.seq = SEQ_LOADED;
                        end
                    end
                    if (s_d.seq == SEQ_HV && s_q.seq != SEQ_HV) begin
                        s_d.op_busy = 1'b1;
                        if (s_q.ee_cfg || !s_q.pe_erase) begin
                            s_d.op_addr = s_q.ee_addr;
                            s_d.op_left = 12'h001;
                        end else if (s_q.pe_byte) begin
                            s_d.op_addr = s_q.ee_addr;
                            s_d.op_left = 12'h001;
                        end else if (s_q.pe_row) begin
                            s_d.op_addr = s_q.ee_addr & `NVPC_ROW_MASK;
                            s_d.op_left = `NVPC_ROW_LEN;
                        end else begin
                            s_d.op_addr = 11'h000;
                            s_d.op_left = 12'(EE_SIZE);
                        end
                    end
                end
                `NVPC_OFS_OPTION: begin
                    s_d.pump_clock_select = REG_WDATA[`NVPC_OPT_PUMP_CLOCK_SELECT];
                end
            endcase
        end

        // register reads; special-only fields read zero in normal modes
        if (REG_RD) begin
            unique case (REG_ADDR)
                `NVPC_OFS_EPROM_PROGRAM_REGISTER: begin
                    s_d.rdata[`NVPC_EP_MBE]  = s_q.ep_mbe && SPECIAL_MODE;
                    s_d.rdata[`NVPC_EP_EPROM_LATCH_ENABLE] = s_q.ep_eprom_latch_enable;
                    s_d.rdata[`NVPC_EP_XCOL] = s_q.ep_xcol && SPECIAL_MODE;
                    s_d.rdata[`NVPC_EP_XROW] = s_q.ep_xrow && SPECIAL_MODE;
                    if (SPECIAL_MODE) begin
                        s_d.rdata[`NVPC_EP_T_HI:`NVPC_EP_T_LO] = s_q.ep_t;
                    end
                    s_d.rdata[`NVPC_EP_PGM]  = s_q.ep_pgm;
                end
                `NVPC_OFS_EEPROM_BLOCK_PROTECT: begin
                    s_d.rdata[4:0] = s_q.bp;
                end
                `NVPC_OFS_PECTL: begin
                    s_d.rdata[`NVPC_PE_BYTE]  = s_q.pe_byte;
                    s_d.rdata[`NVPC_PE_ROW]   = s_q.pe_row;
                    s_d.rdata[`NVPC_PE_ERASE] = s_q.pe_erase;
                    s_d.rdata[`NVPC_PE_EEPROM_LATCH_ENABLE] = s_q.pe_eeprom_latch_enable;
                    s_d.rdata[`NVPC_PE_EEPROM_VOLTAGE_ENABLE]  = s_q.pe_eeprom_voltage_enable;
                end
                `NVPC_OFS_OPTION: begin
                    s_d.rdata[`NVPC_OPT_PUMP_CLOCK_SELECT] = s_q.pump_clock_select;
                end
            endcase
        end

        // cpu writes to memory space
        if (MEM_WR) begin
            if ((ee_hit || cfg_hit) && s_q.pe_eeprom_latch_enable && !s_q.pe_eeprom_voltage_enable) begin
                s_d.ee_addr = cfg_hit ? 11'h000 : mem_off;
                s_d.ee_data = MEM_WDATA;
                s_d.ee_cfg  = cfg_hit;
                if (s_q.seq == SEQ_ARMED) begin
                    s_d.seq = SEQ_LOADED;
                end
            end
            if (ep_hit && s_q.ep_eprom_latch_enable && !s_q.ep_pgm) begin
                s_d.ep_addr = MEM_ADDR[13:0];
                s_d.ep_data = MEM_WDATA;
            end
        end

        // cpu reads; latched paths return zero
        if (MEM_RD && !s_q.pe_eeprom_latch_enable) begin
            if (cfg_hit) begin
                s_d.mrdata = s_q.cfg_word;
            end else if (ee_hit) begin
                s_d.mrdata = arr[mem_off[EE_AW-1:0]];
            end
        end

        // program or erase step, cut short when voltage drops
        if (s_q.op_busy) begin
            if (!s_q.pe_eeprom_voltage_enable || s_q.op_left == 12'h001) begin
                s_d.op_busy = 1'b0;
            end
            s_d.op_addr = 11'(s_q.op_addr + 11'h001);
            s_d.op_left = 12'(s_q.op_left - 12'h001);
            if (s_q.pe_eeprom_voltage_enable && s_q.ee_cfg && !op_prot) begin
                if (s_q.pe_erase) begin
                    s_d.cfg_word = 8'hff;
                end else begin
                    s_d.cfg_word = s_q.cfg_word & s_q.ee_data;
                end
            end
        end
        if (!s_d.pe_eeprom_voltage_enable) begin
            s_d.op_busy = 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            s_q          <= '0;
            s_q.ep_t     <= STRESS_NORMAL;
            s_q.seq      <= SEQ_IDLE;
            s_q.bp       <= `NVPC_BP_RST;
            s_q.cfg_word <= `NVPC_CFG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // array cells hold their value through reset, as nonvolatile cells do
    always_ff @(posedge MCLK) begin
        if (arr_we) begin
            arr[arr_wa[EE_AW-1:0]] <= arr_wd;
        end
    end

    // glitch-free switching is left to the pump; select changes on any
    // option register write, even while an operation runs
    assign PUMP_CLK = s_q.pump_clock_select ? RC_OSC : MCLK;

    always_comb begin
        REG_RDATA = s_q.rdata;
        MEM_RDATA = s_q.mrdata;
        EE_VPP    = s_q.pe_eeprom_voltage_enable;
        EE_BUSY   = s_q.op_busy;
        EPROM.addr     = s_q.ep_addr;
        EPROM.data     = s_q.ep_data;
        EPROM.vpp      = s_q.ep_pgm;
        EPROM.dual     = s_q.ep_mbe && SPECIAL_MODE;
        EPROM.xcol     = s_q.ep_xcol && SPECIAL_MODE;
        EPROM.xrow     = s_q.ep_xrow && SPECIAL_MODE;
        EPROM.stress   = SPECIAL_MODE ? s_q.ep_t : STRESS_NORMAL;
        EPROM.rd_block = s_q.ep_eprom_latch_enable;
        EPROM.care     = 14'h3fff;
        if (EPROM.xcol) begin
            EPROM.care = `NVPC_XCOL_CARE;
        end else if (EPROM.xrow) begin
            EPROM.care = `NVPC_XROW_CARE;
        end
        if (EPROM.dual) begin
            EPROM.care[`NVPC_MBE_BIT] = 1'b0;
        end
    end
endmodule : nvpc_top

// [rtl/nvpc_cfg.svh]
// nvpc_cfg.svh: offsets, bit positions, reset values and counts
// assumes inclusion by nvpc_top.sv, not by nvpc_pkg.sv
`ifndef NVPC_CFG_SVH
`define NVPC_CFG_SVH
`define NVPC_OFS_EPROM_PROGRAM_REGISTER   2'h0
`define NVPC_OFS_EEPROM_BLOCK_PROTECT   2'h1
`define NVPC_OFS_PECTL   2'h2
`define NVPC_OFS_OPTION  2'h3
`define NVPC_EP_MBE      7
`define NVPC_EP_EPROM_LATCH_ENABLE     5
`define NVPC_EP_XCOL     4
`define NVPC_EP_XROW     3
`define NVPC_EP_T_HI     2
`define NVPC_EP_T_LO     1
`define NVPC_EP_PGM      0
`define NVPC_PE_BYTE     4
`define NVPC_PE_ROW      3
`define NVPC_PE_ERASE    2
`define NVPC_PE_EEPROM_LATCH_ENABLE    1
`define NVPC_PE_EEPROM_VOLTAGE_ENABLE     0
`define NVPC_BP_OPTION_WORD_PROTECT    4
`define NVPC_OPT_PUMP_CLOCK_SELECT    0
`define NVPC_BP_RST      5'h1f
`define NVPC_CFG_RST     8'hff
`define NVPC_PROT_WIN    7'h40
`define NVPC_EE_SM_TAG   7'h5b
`define NVPC_EE_BLK1     11'h020
`define NVPC_EE_BLK2     11'h060
`define NVPC_EE_BLK3     11'h0e0
`define NVPC_ROW_MASK    11'h7f0
`define NVPC_ROW_LEN     12'h010
`define NVPC_CFG_ADDR    16'h103f
`define NVPC_EPROM_BASE  16'hd000
`define NVPC_MBE_BIT     5
`define NVPC_XCOL_CARE   14'h3fe0
`define NVPC_XROW_CARE   14'h00ff
`endif

// [rtl/nvpc_pkg.sv]
// nvpc_pkg: types of the nonvolatile program control block
// assumes nvpc_cfg.svh is on the include path
package nvpc_pkg;
    typedef enum logic [1:0] {
        STRESS_NORMAL, STRESS_RSVD, STRESS_GATE, STRESS_DRAIN
    } nvpc_stress_e;
    typedef enum logic [1:0] {
        SEQ_IDLE, SEQ_ARMED, SEQ_LOADED, SEQ_HV
    } nvpc_seq_e;
    typedef struct packed {
        logic [13:0]  addr;
        logic [13:0]  care;
        logic [7:0]   data;
        logic         vpp;
        logic         dual;
        logic         xcol;
        logic         xrow;
        nvpc_stress_e stress;
        logic         rd_block;
    } nvpc_eprom_s;
    typedef struct packed {
        logic         ep_mbe;
        logic         ep_eprom_latch_enable;
        logic         ep_xcol;
        logic         ep_xrow;
        nvpc_stress_e ep_t;
        logic         ep_pgm;
        logic [13:0]  ep_addr;
        logic [7:0]   ep_data;
        logic         pe_byte;
        logic         pe_row;
        logic         pe_erase;
        logic         pe_eeprom_latch_enable;
        logic         pe_eeprom_voltage_enable;
        nvpc_seq_e    seq;
        logic [4:0]   bp;
        logic [6:0]   win_cnt;
        logic         pump_clock_select;
        logic [10:0]  ee_addr;
        logic [7:0]   ee_data;
        logic         ee_cfg;
        logic [10:0]  op_addr;
        logic [11:0]  op_left;
        logic         op_busy;
        logic [7:0]   cfg_word;
        logic [7:0]   rdata;
        logic [7:0]   mrdata;
    } nvpc_state_s;
endpackage : nvpc_pkg

// [tb/nvpc_monitor.sv]
// nvpc_monitor: port-level checks of the program control block
// assumes binding onto nvpc_top, one clock MCLK, reset RESETN
module nvpc_monitor #(
    parameter int EE_LARGE = 0
) (
    input wire logic                  MCLK,
    input wire logic                  RESETN,
    input wire logic                  SPECIAL_MODE,
    input wire logic                  EE_VISIBLE,
    input wire logic [3:0]            EE_BASE,
    input wire logic                  RC_OSC,
    input wire logic [1:0]            REG_ADDR,
    input wire logic [7:0]            REG_WDATA,
    input wire logic                  REG_WR,
    input wire logic                  REG_RD,
    input wire logic [7:0]            REG_RDATA,
    input wire logic [15:0]           MEM_ADDR,
    input wire logic [7:0]            MEM_WDATA,
    input wire logic                  MEM_WR,
    input wire logic                  MEM_RD,
    input wire logic [7:0]            MEM_RDATA,
    input wire logic                  EE_VPP,
    input wire logic                  EE_BUSY,
    input wire logic                  PUMP_CLK,
    input wire nvpc_pkg::nvpc_eprom_s EPROM
);
    timeunit 1ns;
    timeprecision 100ps;
    import nvpc_pkg::*;
    // the longest operation is a bulk erase of the large array, too long for a delay range
    logic [11:0] busy_cnt_q;
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            busy_cnt_q <= 12'h000;
        end else if (EE_BUSY && busy_cnt_q != 12'hfff) begin
            busy_cnt_q <= 12'(busy_cnt_q + 12'h001);
        end else if (!EE_BUSY) begin
            busy_cnt_q <= 12'h000;
        end
    end
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);
    vpp_sequence_a: assert property ($rose(EE_VPP) |-> $past(REG_WR) &&
        $past(REG_ADDR) == 2'h2 && $past(REG_WDATA[1:0]) == 2'h3) else $error("vpp rose");
    vpp_drop_a: assert property (REG_WR && REG_ADDR == 2'h2 && !REG_WDATA[0]
        |=> !EE_VPP) else $error("vpp stayed on");
    busy_vpp_a: assert property ($rose(EE_BUSY) |-> EE_VPP)
        else $error("busy without vpp");
    busy_bound_a: assert property (busy_cnt_q <= 12'h802)
        else $error("busy too long");
    special_gate_a: assert property (!SPECIAL_MODE |-> !(EPROM.dual | EPROM.xcol)
        && !EPROM.xrow && EPROM.stress == STRESS_NORMAL) else $error("special field on");
    xcol_care_a: assert property (EPROM.xcol && !EPROM.xrow && !EPROM.dual
        |-> EPROM.care == 14'h3fe0) else $error("xcol mask");
    xrow_care_a: assert property (EPROM.xrow && !EPROM.xcol && !EPROM.dual
        |-> EPROM.care == 14'h00ff) else $error("xrow mask");
    dual_care_a: assert property (EPROM.dual |-> !EPROM.care[5])
        else $error("dual mask");
    latch_capture_a: assert property (MEM_WR && MEM_ADDR >= 16'hd000 && EPROM.rd_block
        && !EPROM.vpp |=> EPROM.addr == $past(MEM_ADDR[13:0])
        && EPROM.data == $past(MEM_WDATA)) else $error("eprom latch");
    eprom_latch_enable_hold_a: assert property (REG_WR && REG_ADDR == 2'h0 && EPROM.vpp
        |=> EPROM.rd_block) else $error("latch dropped");
    pgm_gate_a: assert property (REG_WR && REG_ADDR == 2'h0 && !EPROM.rd_block
        |=> !EPROM.vpp) else $error("eprom vpp set");
    cover property ($rose(EE_BUSY));
    cover property (EPROM.vpp);
    cover property (REG_WR && REG_ADDR == 2'h1);
endmodule : nvpc_monitor

bind nvpc_top nvpc_monitor #(.EE_LARGE(EE_LARGE)) u_monitor (
    .MCLK(MCLK), .RESETN(RESETN), .SPECIAL_MODE(SPECIAL_MODE), .EE_VISIBLE(EE_VISIBLE),
    .EE_BASE(EE_BASE), .RC_OSC(RC_OSC), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_WR(MEM_WR), .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA),
    .EE_VPP(EE_VPP), .EE_BUSY(EE_BUSY), .PUMP_CLK(PUMP_CLK), .EPROM(EPROM)
);

// [tb/nvpc_cpu.sv]
// nvpc_cpu: processor model issuing register and memory cycles
// assumes strobes of one cycle, signals changed just after a rising edge
module nvpc_cpu (
    input  wire logic        clk,
    output logic [1:0]       reg_addr,
    output logic [7:0]       reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [7:0]  reg_rdata,
    output logic [15:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    output logic             mem_wr,
    output logic             mem_rd,
    input  wire logic [7:0]  mem_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {mem_addr, mem_wdata, mem_wr, mem_rd} = '0;
    end
    // released lines are inverted, so a stale value is never mistaken for a live one
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask : rd_reg
    task automatic wr_mem(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        mem_addr  <= a;
        mem_wdata <= d;
        mem_wr    <= 1'b1;
        @(posedge clk);
        mem_wr    <= 1'b0;
        mem_addr  <= ~a;
        mem_wdata <= ~d;
        #1;
    endtask : wr_mem
    task automatic rd_mem(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        mem_addr <= a;
        mem_rd   <= 1'b1;
        @(posedge clk);
        mem_rd   <= 1'b0;
        mem_addr <= ~a;
        #1 d = mem_rdata;
    endtask : rd_mem
endmodule : nvpc_cpu

// [tb/testbench.sv]
// testbench: register table, eeprom sequences, protect window, pump clock
// assumes nvpc_top with the small array, cpu model driving both ports
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import nvpc_pkg::*;
    typedef struct packed {
        logic       sp;
        logic [1:0] a;
        logic [7:0] wd;
        logic [7:0] rd;
    } nvpc_row_s;
    localparam nvpc_row_s ROWS [18] = '{
        {1'b0,2'h0,8'hfe,8'h20}, {1'b1,2'h0,8'hfe,8'hbe}, {1'b1,2'h0,8'h21,8'h21},
        {1'b1,2'h0,8'h01,8'h21}, {1'b1,2'h0,8'h20,8'h20}, {1'b1,2'h0,8'h00,8'h00},
        {1'b1,2'h0,8'h01,8'h00}, {1'b1,2'h0,8'h30,8'h30}, {1'b1,2'h0,8'h28,8'h28},
        {1'b1,2'h0,8'ha0,8'ha0}, {1'b1,2'h0,8'h22,8'h22}, {1'b1,2'h0,8'h24,8'h24},
        {1'b0,2'h0,8'h00,8'h00}, {1'b0,2'h3,8'h01,8'h01}, {1'b0,2'h3,8'h00,8'h00},
        {1'b0,2'h2,8'h03,8'h00}, {1'b0,2'h2,8'h1e,8'h1e}, {1'b0,2'h2,8'h00,8'h00}};
    logic        mclk, resetn, special_mode, rc_osc, reg_wr, reg_rd, mem_wr, mem_rd;
    logic        ee_vpp, ee_busy, pump_clk;
    logic [1:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, mem_wdata, mem_rdata;
    logic [15:0] mem_addr;
    nvpc_eprom_s eprom;
    int          mismatches, n_compared;
    nvpc_top #(.EE_LARGE(0)) DUT (
        .MCLK(mclk), .RESETN(resetn), .SPECIAL_MODE(special_mode), .EE_VISIBLE(1'b1),
        .EE_BASE(4'h0), .RC_OSC(rc_osc), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .MEM_ADDR(mem_addr),
        .MEM_WDATA(mem_wdata), .MEM_WR(mem_wr), .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata),
        .EE_VPP(ee_vpp), .EE_BUSY(ee_busy), .PUMP_CLK(pump_clk), .EPROM(eprom));
    nvpc_cpu cpu (
        .clk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
    task automatic complete_run();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic chk_reg(input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] d;
        cpu.rd_reg(a, d);
        cmp({8'h00, d}, {8'h00, exp});
    endtask : chk_reg
    task automatic chk_mem(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        cpu.rd_mem(a, d);
        cmp({8'h00, d}, {8'h00, exp});
    endtask : chk_mem
    // arm, load, raise voltage, wait out the operation, then drop everything
    task automatic ee_op(input logic [7:0] ctl, input logic [15:0] a, input logic [7:0] d);
        cpu.wr_reg(2'h2, ctl);
        cpu.wr_mem(a, d);
        cpu.wr_reg(2'h2, ctl | 8'h01);
        for (int i = 0; i < 3000 && ee_busy !== 1'b0; i++) begin
            @(posedge mclk);
            #1;
        end
        cpu.wr_reg(2'h2, 8'h00);
    endtask : ee_op
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        complete_run();
    end
    initial begin
        {resetn, special_mode, rc_osc, mismatches, n_compared} = '0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        foreach (ROWS[i]) begin
            @(posedge mclk);
            special_mode <= ROWS[i].sp;
            cpu.wr_reg(ROWS[i].a, ROWS[i].wd);
            chk_reg(ROWS[i].a, ROWS[i].rd);
        end
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        chk_reg(2'h1, 8'h1f);
        cpu.wr_reg(2'h1, 8'h00);
        chk_reg(2'h1, 8'h00);
        cpu.wr_reg(2'h1, 8'h1f);
        chk_reg(2'h1, 8'h1f);
        repeat (64) @(posedge mclk);
        cpu.wr_reg(2'h1, 8'h00);
        chk_reg(2'h1, 8'h1f);
        special_mode <= 1'b1;
        cpu.wr_reg(2'h1, 8'h00);
        chk_reg(2'h1, 8'h00);
        ee_op(8'h06, 16'hb600, 8'h00);
        chk_mem(16'hb600, 8'hff);
        chk_mem(16'hb7ff, 8'hff);
        ee_op(8'h02, 16'hb610, 8'h5a);
        chk_mem(16'hb610, 8'h5a);
        ee_op(8'h02, 16'hb610, 8'hf0);
        chk_mem(16'hb610, 8'h50);
        ee_op(8'h02, 16'hb620, 8'h00);
        ee_op(8'h0e, 16'hb615, 8'h00);
        chk_mem(16'hb610, 8'hff);
        chk_mem(16'hb620, 8'h00);
        ee_op(8'h1e, 16'hb620, 8'h00);
        chk_mem(16'hb620, 8'hff);
        ee_op(8'h12, 16'hb621, 8'h3c);
        chk_mem(16'hb621, 8'h3c);
        cpu.wr_mem(16'hb600, 8'h00);
        chk_mem(16'hb600, 8'hff);
        cpu.wr_reg(2'h2, 8'h02);
        chk_mem(16'hb600, 8'h00);
        cpu.wr_reg(2'h2, 8'h03);
        cmp({15'h0, ee_vpp}, 16'h0000);
        cpu.wr_reg(2'h2, 8'h00);
        cpu.wr_reg(2'h1, 8'h02);
        ee_op(8'h02, 16'hb620, 8'h00);
        ee_op(8'h02, 16'hb61f, 8'h00);
        chk_mem(16'hb620, 8'hff);
        chk_mem(16'hb61f, 8'h00);
        cpu.wr_reg(2'h1, 8'h10);
        ee_op(8'h02, 16'h103f, 8'h00);
        chk_mem(16'h103f, 8'hff);
        cpu.wr_reg(2'h1, 8'h00);
        ee_op(8'h02, 16'h103f, 8'h0f);
        chk_mem(16'h103f, 8'h0f);
        cpu.wr_reg(2'h3, 8'h01);
        #1 cmp({15'h0, pump_clk}, 16'h0000);
        @(posedge mclk);
        rc_osc <= 1'b1;
        #3 cmp({15'h0, pump_clk}, 16'h0001);
        cpu.wr_reg(2'h3, 8'h00);
        rc_osc <= 1'b0;
        #3 cmp({15'h0, pump_clk}, 16'h0000);
        cpu.wr_reg(2'h0, 8'h20);
        cpu.wr_mem(16'hd123, 8'h77);
        cmp({2'h0, eprom.addr}, 16'h1123);
        cmp({8'h00, eprom.data}, 16'h0077);
        cpu.wr_reg(2'h0, 8'h00);
        complete_run();
    end
endmodule : testbench
